// *** dv/test_touch_timing_ctrl.sv ***
// self-checking bench of the touch timing control block
`default_nettype none
module test_touch_timing_ctrl import touch_timing_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SLOTS = 4;                 // short slots: 32-clock cycle
	localparam int CYC = SLOTS * NUM_INPUTS;
	localparam logic [7:0] ADR [6] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h44,
		8'h30};                               // last one is unmapped
	localparam logic [7:0] MSK [6] = '{8'hF8, 8'hFF, 8'hFF, 8'h0F, 8'hFD,
		8'h00};
	localparam logic [7:0] RSTV [6] = '{8'h20, 8'hFF, 8'hA4, 8'h07, 8'h40,
		8'h00};
	// noise cases: option2, rf, emi, expected touch and noise bits
	localparam logic [15:0] NZ [5] = '{16'h4081, 16'h4483, 16'h4041,
		16'h4840, 16'h4881};
	logic       clk, rst, wr, rd, rvalid, mwr, powered, cstart, irq;
	logic [7:0] addr, wdata, rdata, touch, rf, emi, rep, sel, q, d;
	logic [7:0] tstat, nstat, hstat, recal;
	logic [1:0] pol, mdata, mirror;
	logic [7:0] model [6];                    // expected register contents
	logic [7:0] ens [4];
	logic [7:0] stray;
	int         bad_count, n_compared, irq_n, recal_n, low_n, k, n;
	touch_timing_ctrl #(.SLOT_CYCLES(SLOTS)) touch_timing_ctrl_inst (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_touch_raw(touch),
		.i_rf_noise(rf), .i_emi_noise(emi), .i_repeat_enable(rep),
		.i_led_pol(pol), .i_mirror_wr(mwr), .i_mirror_wdata(mdata),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_sample_select(sel),
		.o_sensor_powered(powered), .o_cycle_start(cstart),
		.o_touch_status(tstat), .o_noise_status(nstat),
		.o_hold_status(hstat), .o_recal_req(recal), .o_irq_pulse(irq),
		.o_led_mirror(mirror));
	touch_host_model touch_host_model_inst (
		.i_clk_sys(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
		.o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
		.o_reg_wdata(wdata));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// event counters on input 1 and the interrupt line
	always @(posedge clk) begin
		if (irq === 1'b1) irq_n <= irq_n + 1;
		if (recal[0] === 1'b1) recal_n <= recal_n + 1;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		touch_host_model_inst.access(1'b1, a, v, q);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		touch_host_model_inst.access(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic do_reset();
		rst = 1'b1;
		cyc(10);
		rst = 1'b0;
	endtask
	// clocks to the next new-cycle pulse, noting selects of disabled inputs
	task automatic to_start(input logic [7:0] en);
		stray = 8'h00;
		n = 0;
		do begin
			@(negedge clk);
			stray |= sel & ~en;
			n++;
		end while (cstart !== 1'b1 && n < 100);
	endtask
	// clocks of the threshold for a code; the hold event comes one tick later
	function automatic int hold_after(input logic [3:0] c);
		return (int'(c) + 1) * CYC;
	endfunction
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard, far beyond the expected few thousand cycles
	initial begin
		#(50 * 20000);
		bad_count++;
		complete_run();
	end
	initial begin
		rst = 1'b1;
		{touch, rf, emi, rep} = 32'h0;
		{pol, mdata, mwr} = 5'h00;
		{bad_count, n_compared, irq_n, recal_n} = 128'h0;
		void'($urandom(77467));
		do_reset();
		for (int i = 0; i < 6; i++) begin
			rchk(ADR[i], RSTV[i]);
		end
		// random writes and reads, unmapped place included
		model = RSTV;
		repeat (24) begin
			k = $urandom_range(5);
			d = 8'($urandom);
			wreg(ADR[k], d);
			model[k] = d & MSK[k];
			k = $urandom_range(5);
			rchk(ADR[k], model[k]);
		end
		// write then read the enable register with one idle cycle
		wreg(8'h21, 8'h5A);
		rchk(8'h21, 8'h5A);
		do_reset();
		rchk(8'h22, 8'hA4);
		// cycle length does not depend on enables
		ens = '{8'h00, 8'h01, 8'h80, 8'h00};
		ens[3] = 8'($urandom);
		foreach (ens[j]) begin
			wreg(8'h21, ens[j]);
			to_start(ens[j]);
			to_start(ens[j]);
			chk(8'(n), 8'(CYC));
			chk(stray, 8'h00);
		end
		// power hold on, then off with only input 1 enabled
		wreg(8'h21, 8'h01);
		for (int i = 0; i < 2; i++) begin
			wreg(8'h44, i == 0 ? 8'h60 : 8'h40);
			cyc(CYC);
			low_n = 0;
			repeat (2 * CYC) @(negedge clk) low_n += int'(powered !== 1'b1);
			chk(8'(low_n != 0), 8'(i));
		end
		wreg(8'h21, 8'hFF);
		// rf and emi filtering and reporting on input 1
		touch = 8'h01;
		foreach (NZ[j]) begin
			wreg(8'h44, NZ[j][15:8]);
			rf = {7'h00, NZ[j][7]};
			emi = {7'h00, NZ[j][6]};
			cyc(3 * CYC);
			chk(8'(tstat[0]), 8'(NZ[j][1]));
			chk(8'(nstat[0]), 8'(NZ[j][0]));
		end
		// both filters off: rf and emi together no longer block a touch
		wreg(8'h20, 8'h30);
		wreg(8'h44, 8'h44);
		{rf, emi} = 16'h0101;
		cyc(3 * CYC);
		chk(8'(tstat[0]), 8'h01);
		chk(8'(nstat[0]), 8'h01);
		wreg(8'h20, 8'h20);
		{touch, rf, emi} = 24'h0;
		// press and release interrupts, release suppressed second time
		for (int i = 0; i < 2; i++) begin
			wreg(8'h44, 8'h40 | 8'(i));
			cyc(3 * CYC);
			irq_n = 0;
			touch = 8'h02;
			cyc(2 * CYC);
			touch = 8'h00;
			cyc(2 * CYC);
			chk(8'(irq_n), 8'(2 - i));
		end
		// press-and-hold with threshold code 1, repeat every tick
		wreg(8'h23, 8'h01);
		wreg(8'h22, 8'h00);
		rep = 8'h01;
		touch = 8'h01;
		cyc(hold_after(4'h1) - CYC);
		chk(hstat, 8'h00);
		cyc(3 * CYC);
		chk(hstat, 8'h01);
		irq_n = 0;
		cyc(4 * CYC);
		chk(8'(irq_n >= 3), 8'h01);
		// held long past 560 ms: no recalibration while disabled
		recal_n = 0;
		cyc(20 * CYC);
		chk(8'(recal_n), 8'h00);
		touch = 8'h00;
		wreg(8'h20, 8'h28);
		cyc(3 * CYC);
		recal_n = 0;
		touch = 8'h01;
		cyc(14 * CYC);
		chk(8'(recal_n), 8'h00);
		cyc(6 * CYC);
		chk(8'(recal_n), 8'h01);
		{touch, rep} = 16'h0;
		// mirror follows polarity only while the link is open
		wreg(8'h44, 8'h40);
		pol = 2'b10;
		cyc(4);
		chk({6'h00, mirror}, 8'h02);
		pol = 2'b00;
		cyc(4);
		chk({6'h00, mirror}, 8'h00);
		wreg(8'h44, 8'h50);
		pol = 2'b11;
		cyc(4);
		chk({6'h00, mirror}, 8'h00);
		mdata = 2'b01;
		mwr = 1'b1;
		cyc(1);
		mwr = 1'b0;
		cyc(3);
		chk({6'h00, mirror}, 8'h01);
		complete_run();
	end
endmodule
`default_nettype wire

// *** dv/touch_host_model.sv ***
// host side model: register strobes and read capture for the touch block
`default_nettype none
module touch_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_rvalid,
	output logic            o_reg_wr,
	output logic            o_reg_rd,
	output logic      [7:0] o_reg_addr,
	output logic      [7:0] o_reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end
	// one strobe held over one rising edge, launched on a falling edge;
	// released lines carry the inverse so stale values never look valid
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		@(negedge i_clk_sys);
		o_reg_wr = wr;
		o_reg_rd = !wr;
		o_reg_addr = a;
		o_reg_wdata = d;
		@(negedge i_clk_sys);
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
		n = 0;
		// answer lands one edge after the strobe, wait is bounded
		while (!wr && i_reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge i_clk_sys);
			n++;
		end
		q = i_reg_rdata;
	endtask
endmodule
`default_nettype wire

// *** logic/slot_divider.sv ***
// divider giving one-cycle enable pulses at a fixed period
`default_nettype none
module slot_divider
	import touch_timing_pkg::*;
#(
	parameter int unsigned DIV = 2
) (
	input  wire logic i_clk_sys,
	input  wire logic i_sys_rst,
	output var  logic o_pulse
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	typedef struct packed {
		logic [W-1:0] cnt;   // cycles into the period
		logic         pulse; // registered enable
	} div_state_type;
	div_state_type st, next_st;

	// count and wrap
	always_comb begin
		next_st = st;
		next_st.pulse = (st.cnt == LAST);
		next_st.cnt = (st.cnt == LAST) ? '0 : st.cnt + W'(1);
	end

	// state register
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pulse = st.pulse;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	property p_div_gap;
		o_pulse |=> !o_pulse;
	endproperty
	a_div_gap: assert property (p_div_gap)
		else $error("divider pulse lasted two cycles");
endmodule
`default_nettype wire

// *** logic/touch_hold_timer.sv ***
// per-input touch duration timer: press, release, hold, repeat, recal
`default_nettype none
module touch_hold_timer
	import touch_timing_pkg::*;
(
	input  wire logic         i_clk_sys,
	input  wire logic         i_sys_rst,
	input  wire logic         i_tick,
	input  wire logic         i_touch,
	input  wire chan_cfg_type i_cfg,
	output var  chan_evt_type o_evt
);
	typedef struct packed {
		logic       touched;    // last seen touch level
		logic [8:0] cnt;        // ticks touched
		logic [8:0] rcnt;       // ticks since last repeat
		logic       held;       // press-and-hold reached
		logic       recal_done; // one recal per touch
	} timer_state_type;
	timer_state_type st, next_st;

	// edge detection and duration counting
	always_comb begin
		logic [9:0] cnt1;
		logic [9:0] rcnt1;
		cnt1 = {1'b0, st.cnt} + 10'h001;
		rcnt1 = {1'b0, st.rcnt} + 10'h001;
		next_st = st;
		o_evt = '0;
		next_st.touched = i_touch;
		if (i_touch && !st.touched) begin
			// fresh press restarts everything
			o_evt.press = 1'b1;
			next_st.cnt = '0;
			next_st.rcnt = '0;
			next_st.held = 1'b0;
			next_st.recal_done = 1'b0;
		end else if (!i_touch && st.touched) begin
			o_evt.release_ = 1'b1;
			next_st.held = 1'b0;
		end else if (i_touch && i_tick) begin
			if (st.cnt != CNT_SAT) begin
				next_st.cnt = cnt1[8:0];
			end
			// longer than threshold only
			if (i_cfg.repeat_en && !st.held &&
			    cnt1 > {1'b0, i_cfg.thr}) begin
				next_st.held = 1'b1;
				o_evt.hold = 1'b1;
			end
			// repeat interval runs once held
			if (st.held) begin
				if (rcnt1 >= {1'b0, i_cfg.rpt}) begin
					next_st.rcnt = '0;
					o_evt.repeat_ = 1'b1;
				end else begin
					next_st.rcnt = rcnt1[8:0];
				end
			end
			// recal only with the enable set
			if (i_cfg.recal_en && !st.recal_done &&
			    cnt1 == {1'b0, i_cfg.max}) begin
				o_evt.recal = 1'b1;
				next_st.recal_done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	property p_recal_gated;
		o_evt.recal |-> i_cfg.recal_en && i_touch;
	endproperty
	a_recal_gated: assert property (p_recal_gated)
		else $error("recalibration without enable");
	property p_recal_time;
		o_evt.recal |-> ({1'b0, st.cnt} + 10'h001) == {1'b0, i_cfg.max};
	endproperty
	a_recal_time: assert property (p_recal_time)
		else $error("recalibration at wrong duration");
	property p_hold_late;
		o_evt.hold |-> st.cnt >= i_cfg.thr && i_cfg.repeat_en;
	endproperty
	a_hold_late: assert property (p_hold_late)
		else $error("press-and-hold flagged too early");
	property p_repeat_after_hold;
		o_evt.repeat_ |-> st.held && i_tick;
	endproperty
	a_repeat_after_hold: assert property (p_repeat_after_hold)
		else $error("repeat without hold");
endmodule
`default_nettype wire

// *** logic/touch_timing_ctrl.sv ***
// touch input enable, timing, noise and option control, top level
`default_nettype none
module touch_timing_ctrl
	import touch_timing_pkg::*;
#(
	parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic [7:0] i_touch_raw,
	input  wire logic [7:0] i_rf_noise,
	input  wire logic [7:0] i_emi_noise,
	input  wire logic [7:0] i_repeat_enable,
	input  wire logic [1:0] i_led_pol,
	input  wire logic       i_mirror_wr,
	input  wire logic [1:0] i_mirror_wdata,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	output logic      [7:0] o_sample_select,
	output logic            o_sensor_powered,
	output logic            o_cycle_start,
	output logic      [7:0] o_touch_status,
	output logic      [7:0] o_noise_status,
	output logic      [7:0] o_hold_status,
	output logic      [7:0] o_recal_req,
	output logic            o_irq_pulse,
	output logic      [1:0] o_led_mirror
);
	// whole block state in one record
	typedef struct packed {
		reg_file_type regs;    // host visible fields
		logic [2:0]   slot;    // current sampling slot
		logic [7:0]   touched; // filtered touch per input
		logic [7:0]   noise;   // reported noise per input
		logic [7:0]   hold;    // press-and-hold seen
		logic [7:0]   recal;   // recal request pulses
		logic [7:0]   sel;     // slot select out
		logic [1:0]   pol_q;   // last seen polarity
		logic [1:0]   mirror;  // mirror controls
		logic [7:0]   rdata;   // read data
		logic         rvalid;  // read answer
		logic         powered; // sensing powered
		logic         cyc;     // cycle start pulse
		logic         irq;     // interrupt pulse
	} ctrl_state_type;
	ctrl_state_type st, next_st;

	logic         slot_pulse;   // one sampling slot elapsed
	logic         cycle_tick;   // full cycle, 35ms
	logic [7:0]   sample_mask;  // input sampled this slot
	logic [7:0]   blocked;      // delta forced to zero
	logic [7:0]   noise_seen;   // noise that status may show
	logic [7:0]   above_mask;   // slots later in the cycle
	logic [7:0]   ev_press;     // per input press events
	logic [7:0]   ev_release;   // per input release events
	logic [7:0]   ev_repeat;    // per input repeat events
	logic [7:0]   ev_hold;      // per input hold events
	logic [7:0]   ev_recal;     // per input recal events
	chan_cfg_type cfg [NUM_INPUTS]; // per input timer setup
	chan_evt_type evt [NUM_INPUTS]; // per input timer events

	// option bits pulled out for readability
	logic pwr_hold;
	logic pol_block;
	logic rf_only;
	logic rf_dis;
	logic rel_sup;
	logic emi_dis;
	logic recal_en;
	assign pwr_hold  = st.regs.opt2[BIT_PWR_HOLD];
	assign pol_block = st.regs.opt2[BIT_POL_BLOCK];
	assign rf_only   = st.regs.opt2[BIT_RF_ONLY];
	assign rf_dis    = st.regs.opt2[BIT_RF_DIS];
	assign rel_sup   = st.regs.opt2[BIT_REL_SUP];
	assign emi_dis   = st.regs.opt[BIT_EMI_DIS];
	assign recal_en  = st.regs.opt[BIT_RECAL_EN];

	// slot timebase: eight slots always make one cycle, so the
	// cycle length does not move when inputs are disabled
	slot_divider #(
		.DIV (SLOT_CYCLES)
	) u_slot_div (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.o_pulse   (slot_pulse)
	);
	assign cycle_tick = slot_pulse && (st.slot == LAST_SLOT);

	// one duration timer per input, all fed the same cycle tick
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_timer
		always_comb begin
			cfg[i].thr = step_ticks(st.regs.press[3:0]);
			cfg[i].max = max_hold_ticks(st.regs.hold_rpt[7:4]);
			cfg[i].rpt = step_ticks(st.regs.hold_rpt[3:0]);
			cfg[i].recal_en = recal_en;
			cfg[i].repeat_en = i_repeat_enable[i];
		end
		touch_hold_timer u_timer (
			.i_clk_sys (i_clk_sys),
			.i_sys_rst (i_sys_rst),
			.i_tick    (cycle_tick),
			.i_touch   (st.touched[i]),
			.i_cfg     (cfg[i]),
			.o_evt     (evt[i])
		);
		assign ev_press[i]   = evt[i].press;
		assign ev_release[i] = evt[i].release_;
		assign ev_repeat[i]  = evt[i].repeat_;
		assign ev_hold[i]    = evt[i].hold;
		assign ev_recal[i]   = evt[i].recal;
	end

	// sampling and noise qualification of the current slot
	always_comb begin
		sample_mask = slot_pulse ?
			(slot_mask(st.slot) & st.regs.en) : 8'h00;
		// rf blocks unless disabled, emi unless its filter is off
		blocked = (rf_dis ? 8'h00 : i_rf_noise) |
			(emi_dis ? 8'h00 : i_emi_noise);
		// emi stays out of status in rf-only mode
		noise_seen = rf_only ? i_rf_noise :
			(i_rf_noise | i_emi_noise);
		// slots after the current one, used for power decisions
		above_mask = ~(8'(slot_mask(st.slot) << 1) - 8'h01);
	end

	// next state of the whole block
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		next_st.cyc = cycle_tick;
		// host writes, unused bits forced to zero
		if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_GLOBAL_OPT: begin
					next_st.regs.opt = i_reg_wdata & MASK_GLOBAL_OPT;
				end
				ADDR_INPUT_EN: begin
					next_st.regs.en = i_reg_wdata;
				end
				ADDR_HOLD_RPT: begin
					next_st.regs.hold_rpt = i_reg_wdata;
				end
				ADDR_PRESS_HOLD: begin
					next_st.regs.press = i_reg_wdata & MASK_PRESS_HOLD;
				end
				ADDR_GLOBAL_OPT2: begin
					next_st.regs.opt2 = i_reg_wdata & MASK_GLOBAL_OPT2;
				end
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end
		// host reads, answered one cycle later
		if (i_reg_rd) begin
			next_st.rvalid = 1'b1;
			case (i_reg_addr)
				ADDR_GLOBAL_OPT: begin
					next_st.rdata = st.regs.opt;
				end
				ADDR_INPUT_EN: begin
					next_st.rdata = st.regs.en;
				end
				ADDR_HOLD_RPT: begin
					next_st.rdata = st.regs.hold_rpt;
				end
				ADDR_PRESS_HOLD: begin
					next_st.rdata = st.regs.press;
				end
				ADDR_GLOBAL_OPT2: begin
					next_st.rdata = st.regs.opt2;
				end
				default: begin
					next_st.rdata = 8'h00; // unmapped reads zero
				end
			endcase
		end
		// slot advance, wraps after eight whatever is enabled
		if (slot_pulse) begin
			next_st.slot = st.slot + 3'h1;
		end
		// touch level: sampled inputs update, excluded ones drop
		next_st.touched = ((st.touched & ~sample_mask) |
			(i_touch_raw & ~blocked & sample_mask)) &
			st.regs.en;
		// noise status only moves for the sampled input
		next_st.noise = (st.noise & ~sample_mask) |
			(noise_seen & sample_mask);
		next_st.sel = slot_mask(st.slot) & st.regs.en;
		// powered while a conversion is due in this cycle; in the
		// idle tail only the hold bit keeps the sensor alive
		next_st.powered = pwr_hold ||
			((st.regs.en & (slot_mask(st.slot) | above_mask))
			!= 8'h00);
		// hold flag: a new hold wins over a same-cycle release
		next_st.hold = (st.hold & ~ev_release) | ev_hold;
		next_st.recal = ev_recal;
		// interrupt: press and repeat always, release unless muted
		next_st.irq = (ev_press != 8'h00) ||
			(ev_repeat != 8'h00) ||
			(!rel_sup && (ev_release != 8'h00));
		// mirror: host writes first, a polarity change overrides
		next_st.pol_q = i_led_pol;
		if (i_mirror_wr) begin
			next_st.mirror = i_mirror_wdata;
		end
		if (!pol_block) begin
			// changed polarity bits are copied into the mirror
			next_st.mirror = (next_st.mirror &
				~(i_led_pol ^ st.pol_q)) |
				(i_led_pol & (i_led_pol ^ st.pol_q));
		end
		// with the link blocked only host writes change the mirror
	end

	// state register, reset values set the documented defaults
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
			st.regs.opt <= RST_GLOBAL_OPT;
			st.regs.en <= RST_INPUT_EN;
			st.regs.hold_rpt <= RST_HOLD_RPT;
			st.regs.press <= RST_PRESS_HOLD;
			st.regs.opt2 <= RST_GLOBAL_OPT2;
			st.powered <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign o_reg_rdata      = st.rdata;
	assign o_reg_rvalid     = st.rvalid;
	assign o_sample_select  = st.sel;
	assign o_sensor_powered = st.powered;
	assign o_cycle_start    = st.cyc;
	assign o_touch_status   = st.touched;
	assign o_noise_status   = st.noise;
	assign o_hold_status    = st.hold;
	assign o_recal_req      = st.recal;
	assign o_irq_pulse      = st.irq;
	assign o_led_mirror     = st.mirror;

	// helper: slots counted between cycle starts
	logic [3:0] slots_seen;
	logic       cycle_seen;
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			slots_seen <= 4'h0;
			cycle_seen <= 1'b0;
		end else if (o_cycle_start) begin
			slots_seen <= slot_pulse ? 4'h1 : 4'h0;
			cycle_seen <= 1'b1;
		end else if (slot_pulse) begin
			slots_seen <= slots_seen + 4'h1;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	property p_power_hold;
		pwr_hold |=> o_sensor_powered;
	endproperty
	a_power_hold: assert property (p_power_hold)
		else $error("sensor powered down despite hold bit");
	property p_mirror_link;
		!pol_block && (i_led_pol != st.pol_q) |=>
			((o_led_mirror ^ $past(i_led_pol)) &
			$past(i_led_pol ^ st.pol_q)) == 2'h0;
	endproperty
	a_mirror_link: assert property (p_mirror_link)
		else $error("mirror did not follow polarity");
	property p_mirror_block;
		pol_block && !i_mirror_wr |=> $stable(o_led_mirror);
	endproperty
	a_mirror_block: assert property (p_mirror_block)
		else $error("mirror changed while link blocked");
	property p_noise_both;
		!rf_only |=> (o_noise_status & $past(sample_mask)) ==
			$past((i_rf_noise | i_emi_noise) & sample_mask);
	endproperty
	a_noise_both: assert property (p_noise_both)
		else $error("noise status missed rf or emi");
	property p_noise_rf;
		rf_only |=> (o_noise_status & $past(sample_mask)) ==
			$past(i_rf_noise & sample_mask);
	endproperty
	a_noise_rf: assert property (p_noise_rf)
		else $error("emi shown in rf-only mode");
	property p_rf_block;
		!rf_dis |=> (o_touch_status &
			$past(sample_mask & i_rf_noise)) == 8'h00;
	endproperty
	a_rf_block: assert property (p_rf_block)
		else $error("touch passed despite rf filter");
	property p_rf_pass;
		rf_dis && emi_dis |=> (o_touch_status & $past(sample_mask))
			== $past(i_touch_raw & sample_mask);
	endproperty
	a_rf_pass: assert property (p_rf_pass)
		else $error("touch blocked with filters off");
	sequence s_release_only;
		(ev_release != 8'h00) && (ev_press == 8'h00) &&
			(ev_repeat == 8'h00);
	endsequence
	property p_release_irq;
		!rel_sup and s_release_only |=> o_irq_pulse;
	endproperty
	a_release_irq: assert property (p_release_irq)
		else $error("no interrupt on release");
	property p_release_quiet;
		rel_sup and s_release_only |=> !o_irq_pulse;
	endproperty
	a_release_quiet: assert property (p_release_quiet)
		else $error("interrupt on suppressed release");
	property p_excluded;
		1'b1 |=> (o_touch_status & ~$past(st.regs.en)) == 8'h00;
	endproperty
	a_excluded: assert property (p_excluded)
		else $error("disabled input shows touch");
	property p_cycle_len;
		o_cycle_start && cycle_seen |-> slots_seen == 4'h8;
	endproperty
	a_cycle_len: assert property (p_cycle_len)
		else $error("sampling cycle not eight slots");
	property p_readback;
		i_reg_wr && !i_reg_rd && (i_reg_addr == ADDR_INPUT_EN)
			##1 !i_reg_wr
			##1 i_reg_rd && !i_reg_wr &&
			(i_reg_addr == ADDR_INPUT_EN)
			|=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 3);
	endproperty
	a_readback: assert property (p_readback)
		else $error("enable register read back wrong");
	property p_press_upper;
		o_reg_rvalid && $past(i_reg_addr == ADDR_PRESS_HOLD)
			|-> o_reg_rdata[7:4] == 4'h0;
	endproperty
	a_press_upper: assert property (p_press_upper)
		else $error("unused threshold bits not zero");
endmodule
`default_nettype wire

// *** shared/touch_timing_pkg.sv ***
// constants, register map and carrier types of the touch timing block
`default_nettype none
package touch_timing_pkg;
	// register map
	localparam logic [7:0] ADDR_GLOBAL_OPT  = 8'h20;
	localparam logic [7:0] ADDR_INPUT_EN    = 8'h21;
	localparam logic [7:0] ADDR_HOLD_RPT    = 8'h22;
	localparam logic [7:0] ADDR_PRESS_HOLD  = 8'h23;
	localparam logic [7:0] ADDR_GLOBAL_OPT2 = 8'h44;
	// reset values
	localparam logic [7:0] RST_GLOBAL_OPT   = 8'h20;
	localparam logic [7:0] RST_INPUT_EN     = 8'hFF;
	localparam logic [7:0] RST_HOLD_RPT     = 8'hA4;
	localparam logic [7:0] RST_PRESS_HOLD   = 8'h07;
	localparam logic [7:0] RST_GLOBAL_OPT2  = 8'h40;
	// implemented bits, the rest read zero
	localparam logic [7:0] MASK_GLOBAL_OPT  = 8'hF8;
	localparam logic [7:0] MASK_PRESS_HOLD  = 8'h0F;
	localparam logic [7:0] MASK_GLOBAL_OPT2 = 8'hFD;
	// bit positions
	localparam int BIT_RECAL_EN  = 3;
	localparam int BIT_EMI_DIS   = 4;
	localparam int BIT_PWR_HOLD  = 5;
	localparam int BIT_POL_BLOCK = 4;
	localparam int BIT_RF_ONLY   = 3;
	localparam int BIT_RF_DIS    = 2;
	localparam int BIT_REL_SUP   = 0;
	localparam int NUM_INPUTS    = 8;
	localparam int NUM_LEDS      = 2;
	localparam logic [2:0] LAST_SLOT = 3'h7;
	// timing: one 35ms tick per full sampling cycle
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_MS       = 35;
	localparam int NS_PER_MS     = 1000000;
	localparam int TICK_CYCLES   = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int SLOT_CYCLES_DEF = TICK_CYCLES / NUM_INPUTS;
	localparam logic [8:0] CNT_SAT = 9'h1FF;
	// recalibration time in ticks, rounded up
	function automatic logic [8:0] max_hold_ticks(input logic [3:0] code);
		int ms;
		case (code)
			4'h0: ms = 560;
			4'h1: ms = 840;
			4'h2: ms = 1120;
			4'h3: ms = 1400;
			4'h4: ms = 1680;
			4'h5: ms = 2240;
			4'h6: ms = 2800;
			4'h7: ms = 3360;
			4'h8: ms = 3920;
			4'h9: ms = 4480;
			4'hA: ms = 5600;
			4'hB: ms = 6720;
			4'hC: ms = 7840;
			4'hD: ms = 8906;
			4'hE: ms = 10080;
			default: ms = 11200;
		endcase
		return 9'((ms + TICK_MS - 1) / TICK_MS);
	endfunction
	// code plus one ticks of 35ms
	function automatic logic [8:0] step_ticks(input logic [3:0] code);
		return {5'h00, code} + 9'h001;
	endfunction
	// one-hot of a sampling slot
	function automatic logic [7:0] slot_mask(input logic [2:0] slot);
		return 8'h01 << slot;
	endfunction
	typedef struct packed {
		logic [7:0] opt;
		logic [7:0] en;
		logic [7:0] hold_rpt;
		logic [7:0] press;
		logic [7:0] opt2;
	} reg_file_type;
	typedef struct packed {
		logic [8:0] thr;
		logic [8:0] max;
		logic [8:0] rpt;
		logic       recal_en;
		logic       repeat_en;
	} chan_cfg_type;
	typedef struct packed {
		logic press;
		logic release_;
		logic repeat_;
		logic hold;
		logic recal;
	} chan_evt_type;
endpackage
`default_nettype wire
